/* File: rtl/lbr_defines.vh */
// Purpose: shared constants for the loopback retimer and its buffer
// Assumes: symbols arrive already decoded beside their raw 10-bit code
// Notes:   definitions only, no logic
`ifndef LBR_DEFINES_VH
`define LBR_DEFINES_VH

// ----------------------------------------------------------------------
// decoded control characters (byte value with k flag set)
// ----------------------------------------------------------------------
`define LBR_K_SKP      8'h3C
`define LBR_K_COM      8'hBC
`define LBR_K_BRST     8'hFC
`define LBR_K_BERC     8'h7C

// ----------------------------------------------------------------------
// checker scrambler
// ----------------------------------------------------------------------
`define LBR_LFSR_SEED  16'hFFFF
`define LBR_LFSR_TAPS  16'h0039
`define LBR_EC_MAX     8'hFF
`define LBR_EC_ZERO    8'h00

// ----------------------------------------------------------------------
// datapath and buffer shape
// ----------------------------------------------------------------------
`define LBR_DW         132
`define LBR_SYM_W      10
`define LBR_FIFO_DEPTH 32
`define LBR_FIFO_AW    5
`define LBR_FILL_HI    6'd20
`define LBR_FILL_LO    6'd12

// ----------------------------------------------------------------------
// timing: nominal symbol period and local clock period
// ----------------------------------------------------------------------
`define LBR_SYM_PER_NS 48
`define LBR_CLK_PER_NS 5
`define LBR_TX_CYC     ((`LBR_SYM_PER_NS + `LBR_CLK_PER_NS - 1) / `LBR_CLK_PER_NS)

`endif

/* File: rtl/lbr_fifo.v */
// Purpose: clock tolerance buffer between receive and transmit cadence
// Assumes: single clock; push and pop are one-cycle qualified handshakes
// Notes:   recenter puts the fill level back at half depth
`timescale 1ns/1ps
`include "lbr_defines.vh"

module lbr_fifo #(
  parameter W     = 134,
  parameter DEPTH = `LBR_FIFO_DEPTH,
  parameter AW    = `LBR_FIFO_AW
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire         flush_i,
  input  wire         recenter_i,
  input  wire         in_vld_i,
  output wire         in_rdy_o,
  input  wire [W-1:0] in_dat_i,
  output wire         out_vld_o,
  input  wire         out_rdy_i,
  output wire [W-1:0] out_dat_o,
  output wire [AW:0]  level_o
);

  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] HALF = DEPTH / 2;

  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;

  wire push = in_vld_i & in_rdy_o;
  wire pop  = out_vld_o & out_rdy_i;

  assign in_rdy_o  = (cnt_q != FULL);
  assign out_vld_o = (cnt_q != {(AW+1){1'b0}});
  assign out_dat_o = mem_q[rd_q];
  assign level_o   = cnt_q;

  integer i;

  // storage; cleared at reset so a recenter never replays unknown words
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {W{1'b0}};
      end
    end else if (push) begin
      mem_q[wr_q] <= in_dat_i;
    end
  end

  // pointers; recenter replays or drops entries to land at half fill
  always @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (recenter_i) begin
      // a word pushed in the recenter cycle is kept as the newest entry
      wr_q  <= wr_q + {{(AW-1){1'b0}}, push};
      rd_q  <= wr_q + {{(AW-1){1'b0}}, push} - HALF[AW-1:0];
      cnt_q <= HALF;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // lbr_fifo

/* File: rtl/lbr_retimer.v */
// Purpose: retimed receiver loopback with clock compensation and error test
// Assumes: receive clock and data come from the recovered-clock pins;
//          a decoder beside the pins delivers byte and k flag per symbol
// Notes:   transmit cadence comes from a divider of the local clock
`timescale 1ns/1ps
`include "lbr_defines.vh"

module lbr_retimer #(
  parameter DW      = `LBR_DW,
  parameter DEPTH   = `LBR_FIFO_DEPTH,
  parameter AW      = `LBR_FIFO_AW,
  parameter TX_DIV  = `LBR_TX_CYC,
  parameter BERT_EN = 1
) (
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          lb_active_i,
  input  wire          gen2_i,
  input  wire          rx_clk_i,
  input  wire [DW-1:0] rx_dat_i,
  input  wire [7:0]    rx_byte_i,
  input  wire          rx_k_i,
  output reg  [DW-1:0] tx_dat_o,
  output reg           tx_enc_o,
  output reg           tx_vld_o,
  output reg  [7:0]    err_cnt_o,
  output reg           bert_run_o,
  output reg           recenter_o
);

  localparam FW = DW + 2;
  localparam [7:0] TX_DIV_M1 = TX_DIV - 1;

  // ----------------------------------------------------------------------
  // scrambler helpers
  // ----------------------------------------------------------------------

  // expected byte of scrambled zero for the current LFSR state
  function [7:0] scr_byte;
    input [15:0] s;
    integer i;
    reg [15:0] t;
    begin
      t = s;
      scr_byte = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        scr_byte[i] = t[15];
        t = {t[14:0], 1'b0} ^ (t[15] ? `LBR_LFSR_TAPS : 16'h0000);
      end
    end
  endfunction

  // LFSR state eight shifts on
  function [15:0] lfsr_adv;
    input [15:0] s;
    integer i;
    reg [15:0] t;
    begin
      t = s;
      for (i = 0; i < 8; i = i + 1) begin
        t = {t[14:0], 1'b0} ^ (t[15] ? `LBR_LFSR_TAPS : 16'h0000);
      end
      lfsr_adv = t;
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------

  reg          rxc_q1;
  reg          rxc_q2;
  reg          rxc_q3;
  reg [DW-1:0] dat_q1;
  reg [DW-1:0] dat_q2;
  reg [7:0]    byte_q1;
  reg [7:0]    byte_q2;
  reg          k_q1;
  reg          k_q2;

  // data rides the same two stages as the clock so they stay aligned
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rxc_q1  <= 1'b0;
      rxc_q2  <= 1'b0;
      rxc_q3  <= 1'b0;
      dat_q1  <= {DW{1'b0}};
      dat_q2  <= {DW{1'b0}};
      byte_q1 <= 8'h00;
      byte_q2 <= 8'h00;
      k_q1    <= 1'b0;
      k_q2    <= 1'b0;
    end else begin
      rxc_q1  <= rx_clk_i;
      rxc_q2  <= rxc_q1;
      rxc_q3  <= rxc_q2;
      dat_q1  <= rx_dat_i;
      dat_q2  <= dat_q1;
      byte_q1 <= rx_byte_i;
      byte_q2 <= byte_q1;
      k_q1    <= rx_k_i;
      k_q2    <= k_q1;
    end
  end

  // one pulse per received symbol, rising edge of the recovered clock
  wire rx_stb = rxc_q2 & ~rxc_q3 & lb_active_i;

  // ----------------------------------------------------------------------
  // symbol classification
  // ----------------------------------------------------------------------

  // test commands only exist at gen 1 and only when built in
  wire bert_on = (BERT_EN != 0) & ~gen2_i;
  wire is_skp  = ~gen2_i & k_q2 & (byte_q2 == `LBR_K_SKP);
  wire is_com  = k_q2 & (byte_q2 == `LBR_K_COM);
  wire is_brst = k_q2 & (byte_q2 == `LBR_K_BRST);
  wire is_berc = k_q2 & (byte_q2 == `LBR_K_BERC);

  // ----------------------------------------------------------------------
  // error test state
  // ----------------------------------------------------------------------

  reg [15:0] lfsr_q;
  reg [7:0]  ec_q;
  reg        armed_q;
  reg        run_q;
  reg        prev_com_q;
  reg [1:0]  berc_pos_q;

  wire chr_stb  = rx_stb & bert_on & ~is_skp;
  wire brst_hit = chr_stb & prev_com_q & is_brst;
  wire start    = chr_stb & armed_q & ~k_q2 & ~brst_hit;
  wire checking = chr_stb & ~brst_hit & (run_q | start);
  wire mismatch = k_q2 | (byte_q2 != scr_byte(lfsr_q));
  wire count_it = checking & ~is_berc & mismatch;
  wire ec_full  = (ec_q == `LBR_EC_MAX);

  // reset set reloads; from the first data character after it, every non-SKP character steps the LFSR
  always @(posedge clk_i) begin
    if (!rst_n_i || !lb_active_i) begin
      lfsr_q  <= `LBR_LFSR_SEED;
      ec_q    <= `LBR_EC_ZERO;
      armed_q <= 1'b0;
      run_q   <= 1'b0;
    end else if (brst_hit) begin
      lfsr_q  <= `LBR_LFSR_SEED;
      ec_q    <= `LBR_EC_ZERO;
      armed_q <= 1'b1;
      run_q   <= 1'b0;
    end else if (checking) begin
      lfsr_q  <= lfsr_adv(lfsr_q);
      armed_q <= 1'b0;
      run_q   <= 1'b1;
      if (count_it && !ec_full) begin
        ec_q <= ec_q + 8'h01;
      end
    end
  end

  // COM tracking and position inside a run of query characters
  always @(posedge clk_i) begin
    if (!rst_n_i || !lb_active_i) begin
      prev_com_q <= 1'b0;
      berc_pos_q <= 2'd0;
    end else if (chr_stb) begin
      prev_com_q <= is_com;
      if (is_berc) begin
        berc_pos_q <= berc_pos_q + 2'd1;
      end else begin
        berc_pos_q <= 2'd0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // write side of the retiming buffer
  // ----------------------------------------------------------------------

  // last two query characters become the count, first two pass as is;
  // the count persists, a query never clears it
  wire subst = chr_stb & is_berc & berc_pos_q[1];

  wire [AW:0]   level;
  wire          in_rdy;
  wire          out_vld;
  wire [FW-1:0] out_word;

  // gen 1 drops an incoming SKP when the buffer runs too full
  wire drop_skp = is_skp & (level > `LBR_FILL_HI);
  wire wr_vld   = rx_stb & ~drop_skp;

  // count goes out raw with the encode flag; the transmit encoder applies
  // the running disparity, so the scrambler never touches it
  reg [FW-1:0] wr_word;
  always @* begin
    wr_word = {is_skp, 1'b0, dat_q2};
    if (subst) begin
      wr_word = {1'b0, 1'b1, {(DW-8){1'b0}}, ec_q};
    end
  end

  // ----------------------------------------------------------------------
  // transmit cadence
  // ----------------------------------------------------------------------

  reg [7:0] div_q;
  reg       tick_q;

  // local symbol rate; differs slightly from the far clock on purpose
  always @(posedge clk_i) begin
    if (!rst_n_i || !lb_active_i) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == TX_DIV_M1) begin
      div_q  <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read side: SKP insertion and buffer recentering
  // ----------------------------------------------------------------------

  // a low buffer repeats a SKP at the head instead of popping it
  wire head_skp = out_word[FW-1] & ~gen2_i;  // stale gen 1 flags ignored
  wire ins_skp  = tick_q & out_vld & head_skp &
                  (level < `LBR_FILL_LO);
  wire pop      = tick_q & out_vld & ~ins_skp;

  // gen 2 blocks pass unchanged, so their SKP sets keep legal lengths;
  // only recentering absorbs drift there
  wire ovf      = wr_vld & ~in_rdy;
  wire unf      = tick_q & ~out_vld;
  wire recenter = ovf | unf;

  lbr_fifo #(
    .W     (FW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .flush_i    (~lb_active_i),
    .recenter_i (recenter),
    .in_vld_i   (wr_vld),
    .in_rdy_o   (in_rdy),
    .in_dat_i   (wr_word),
    .out_vld_o  (out_vld),
    .out_rdy_i  (pop),
    .out_dat_o  (out_word),
    .level_o    (level)
  );

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------

  // data always leaves through flops, never straight from the pins
  always @(posedge clk_i) begin
    if (!rst_n_i || !lb_active_i) begin
      tx_dat_o <= {DW{1'b0}};
      tx_enc_o <= 1'b0;
      tx_vld_o <= 1'b0;
    end else if (tick_q && out_vld) begin
      tx_dat_o <= out_word[DW-1:0];
      tx_enc_o <= out_word[DW];
      tx_vld_o <= 1'b1;
    end else begin
      tx_vld_o <= 1'b0;
    end
  end

  // status mirrors for the link controller
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      err_cnt_o  <= `LBR_EC_ZERO;
      bert_run_o <= 1'b0;
      recenter_o <= 1'b0;
    end else begin
      err_cnt_o  <= ec_q;
      bert_run_o <= run_q;
      recenter_o <= recenter & lb_active_i;
    end
  end

endmodule // lbr_retimer

/* File: verif/lbr_retimer_checker.sv */
// Purpose: port checks for the loopback retimer
// Assumes: rate select moves only while loopback is off
// Notes:   bound onto lbr_retimer below the module
`timescale 1ns/1ps

module lbr_retimer_checker (
  input logic         clk_i,
  input logic         rst_n_i,
  input logic         lb_active_i,
  input logic         gen2_i,
  input logic [131:0] tx_dat_o,
  input logic         tx_enc_o,
  input logic         tx_vld_o,
  input logic [7:0]   err_cnt_o,
  input logic         bert_run_o,
  input logic         recenter_o
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // divider keeps pulses at least nine clocks apart, never straight through
  a_tx_spacing: assert property (
    tx_vld_o |=> !tx_vld_o [*8]) else $error("tx pulses too close");
  a_tx_in_loop: assert property (
    tx_vld_o |-> $past(lb_active_i)) else $error("tx outside loopback");
  a_recenter_pulse: assert property (
    recenter_o |=> !recenter_o) else $error("recenter held");
  a_off_clears: assert property (
    !lb_active_i [*3] |-> tx_dat_o == 132'h0 && !bert_run_o
      && err_cnt_o == 8'h00) else $error("loopback off not cleared");
  a_count_sat: assert property (
    err_cnt_o == 8'hFF |=> err_cnt_o inside {8'hFF, 8'h00})
    else $error("count wrapped");
  // a doubled increment, or any step other than +1 or back to zero, shows up as a jump
  a_count_step: assert property (
    err_cnt_o != $past(err_cnt_o) |-> err_cnt_o == 8'h00
      || err_cnt_o - $past(err_cnt_o) == 8'h01) else $error("count jumped");
  a_gen2_no_test: assert property (
    bert_run_o |-> !gen2_i) else $error("test running in gen 2");
  a_tx_hold: assert property (
    lb_active_i && $past(lb_active_i) && !tx_vld_o
      |-> $stable(tx_dat_o) && $stable(tx_enc_o)) else $error("tx moved");

  c_count_sent: cover property (tx_vld_o && tx_enc_o);
  c_saturated: cover property (err_cnt_o == 8'hFF);
  c_recenter: cover property (recenter_o);
endmodule // lbr_retimer_checker

bind lbr_retimer lbr_retimer_checker lbr_retimer_checker_i (
  .clk_i       (clk_i),
  .rst_n_i     (rst_n_i),
  .lb_active_i (lb_active_i),
  .gen2_i      (gen2_i),
  .tx_dat_o    (tx_dat_o),
  .tx_enc_o    (tx_enc_o),
  .tx_vld_o    (tx_vld_o),
  .err_cnt_o   (err_cnt_o),
  .bert_run_o  (bert_run_o),
  .recenter_o  (recenter_o)
);

/* File: verif/lbr_link_model.sv */
// Purpose: far-end tester that drives the receive symbol stream
// Assumes: 48 ns symbol clock, running only inside bursts
// Notes:   a sequence number in the top bits makes each word unique
`timescale 1ns/1ps

module lbr_link_model (
  output logic         rx_clk_o,
  output logic [131:0] rx_dat_o,
  output logic [7:0]   rx_byte_o,
  output logic         rx_k_o
);
  localparam int       HALF_NS = 24;
  localparam logic [7:0] BDAT_SEQ [0:15] = '{8'hFF, 8'h17, 8'hC0, 8'h14,
    8'hB2, 8'hE7, 8'h02, 8'h82, 8'h72, 8'h6E, 8'h28, 8'hA6, 8'hBE,
    8'h6D, 8'hBF, 8'h8D};
  logic [31:0]         seq;

  // ------------------------------------------------------------
  // symbol drivers
  // ------------------------------------------------------------
  // clock parked low, data still unknown until the first burst
  initial begin
    rx_clk_o = 1'b0;
    seq = 32'h0000_0000;
  end

  // change data while the clock is low, hold across the rise
  task automatic blk(input logic [99:0] w, input logic [7:0] b,
                     input logic k);
    seq = seq + 32'h0000_0001;
    rx_dat_o = {seq, w};
    rx_byte_o = b;
    rx_k_o = k;
    #(HALF_NS) rx_clk_o = 1'b1;
    #(HALF_NS) rx_clk_o = 1'b0;
  endtask

  task automatic sym(input logic k, input logic [7:0] b);
    blk({90'h0, k, ~k, b}, b, k);
  endtask

  // reset set is com then the reset character
  task automatic brst();
    sym(1'b1, 8'hBC);
    sym(1'b1, 8'hFC);
  endtask

  // pattern with chosen bytes corrupted, one skp in the middle
  task automatic bdat(input logic [15:0] flip);
    for (int i = 0; i < 16; i++) begin
      if (i == 5) sym(1'b1, 8'h3C);
      sym(1'b0, BDAT_SEQ[i] ^ {8{flip[i]}});
    end
  endtask

  task automatic berc();
    repeat (4) sym(1'b1, 8'h7C);
  endtask

  // end a burst with a skp marker, then let the lines drift
  task automatic rest();
    sym(1'b1, 8'h3C);
    rx_dat_o = ~rx_dat_o;
    rx_byte_o = ~rx_byte_o;
    rx_k_o = ~rx_k_o;
  endtask
endmodule // lbr_link_model

/* File: verif/loopback_bert_retimer_tb.sv */
// Purpose: self-checking bench for the loopback retimer
// Assumes: default divider of ten, symbol clock 48 ns
// Notes:   stale replays after underflow are tolerated by seq markers
`timescale 1ns/1ps

module loopback_bert_retimer_tb;
  logic         clk_i, rst_n_i, lb_active_i, gen2_i;
  logic         rx_clk, rx_k;
  logic [131:0] rx_dat, tx_dat_o, want;
  logic [7:0]   rx_byte, err_cnt_o, enc_b;
  logic         tx_enc_o, tx_vld_o, bert_run_o, recenter_o;
  logic [31:0]  last_seq;
  bit           hit;
  int           enc_n, rc_n, num_errors, samples_checked;

  lbr_retimer lbr_retimer_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .lb_active_i(lb_active_i),
    .gen2_i(gen2_i), .rx_clk_i(rx_clk), .rx_dat_i(rx_dat),
    .rx_byte_i(rx_byte), .rx_k_i(rx_k), .tx_dat_o(tx_dat_o),
    .tx_enc_o(tx_enc_o), .tx_vld_o(tx_vld_o), .err_cnt_o(err_cnt_o),
    .bert_run_o(bert_run_o), .recenter_o(recenter_o));
  lbr_link_model lbr_link_model_i (.rx_clk_o(rx_clk), .rx_dat_o(rx_dat),
    .rx_byte_o(rx_byte), .rx_k_o(rx_k));

  // ------------------------------------------------------------
  // clock, monitor, helpers
  // ------------------------------------------------------------
  always #2.5 clk_i = ~clk_i;

  // sample settled outputs half a cycle after launch
  always @(negedge clk_i) begin
    if (tx_vld_o === 1'b1 && tx_enc_o === 1'b1) begin
      enc_n <= enc_n + 1;
      enc_b <= tx_dat_o[7:0];
    end else if (tx_vld_o === 1'b1) begin
      last_seq <= tx_dat_o[131:100];
      if (tx_dat_o === want) hit <= 1'b1;
    end
    if (recenter_o === 1'b1) rc_n <= rc_n + 1;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [131:0] seen,
                     input logic [131:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait: 0 marker seq seen, 2 recenter count reached
  task automatic wt(input int which, input int n);
    for (int i = 0; i < 4000; i++) begin
      if (which == 0 && last_seq == n) return;
      if (which == 2 && rc_n >= n) return;
      @(negedge clk_i);
    end
    num_errors++;
    $display("[FAIL] wait %0d expected done seen timeout", which);
    complete_run();
  endtask

  task automatic drain();
    lbr_link_model_i.rest();
    wt(0, int'(lbr_link_model_i.seq));
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_bert();
    want = {lbr_link_model_i.seq + 32'h0000_0002, 90'h0, 2'b10, 8'hFC};
    hit = 1'b0;
    lbr_link_model_i.brst();
    lbr_link_model_i.bdat(16'h0208);
    lbr_link_model_i.berc();
    drain();
    chk("reset looped", 132'(hit), 132'h1);
    chk("count byte", 132'(enc_b), 132'h2);
    chk("error count", 132'(err_cnt_o), 132'h2);
    chk("test running", 132'(bert_run_o), 132'h1);
    chk("count sets", 132'(enc_n), 132'h2);
    // a skp parked at the head only moves once eleven words queue behind
    repeat (3) lbr_link_model_i.berc();
    drain();
    chk("count kept", 132'(enc_b), 132'h2);
    chk("count per query", 132'(enc_n), 132'h8);
    chk("query no error", 132'(err_cnt_o), 132'h2);
  endtask

  // control characters all mismatch, pushing the count past its top
  task automatic t_sat();
    for (int i = 0; i < 260; i++) begin
      // local side is slower; a pause keeps the marker skp from a drop
      if (i == 130) begin
        repeat (100) @(negedge clk_i);
      end
      lbr_link_model_i.sym(1'b1, 8'h1C);
    end
    lbr_link_model_i.berc();
    drain();
    chk("count held", 132'(err_cnt_o), 132'hFF);
    chk("count sent", 132'(enc_b), 132'hFF);
    repeat (6) lbr_link_model_i.brst();
    drain();
    chk("count cleared", 132'(err_cnt_o), 132'h0);
  endtask

  // idle link empties the buffer; the underflow must recentre it;
  // armed but idle test ignores these k characters
  task automatic t_recenter();
    repeat (12) lbr_link_model_i.sym(1'b1, 8'h1C);
    wt(2, rc_n + 1);
    chk("recentred", 132'(rc_n > 0), 132'h1);
  endtask

  task automatic t_gen2();
    logic [99:0] pat;
    pat = {4'h5, {3{32'hC3A5_0F96}}};
    lb_active_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("tx cleared", tx_dat_o, 132'h0);
    chk("test stopped", 132'(bert_run_o), 132'h0);
    gen2_i = 1'b1;
    lb_active_i = 1'b1;
    repeat (3) @(negedge clk_i);
    want = {lbr_link_model_i.seq + 32'h0000_0003, pat};
    hit = 1'b0;
    lbr_link_model_i.blk(pat ^ 100'h1, 8'hBC, 1'b1);
    lbr_link_model_i.blk(pat ^ 100'h2, 8'hFC, 1'b1);
    lbr_link_model_i.blk(pat, 8'h7C, 1'b1);
    drain();
    chk("block whole", 132'(hit), 132'h1);
    chk("no test gen2", 132'(bert_run_o), 132'h0);
    chk("no count gen2", 132'(err_cnt_o), 132'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    lb_active_i = 1'b0;
    gen2_i = 1'b0;
    want = 132'h0;
    {hit, enc_n, rc_n, num_errors, samples_checked} = '0;
    {enc_b, last_seq} = '0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    lb_active_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_bert();
    t_sat();
    t_recenter();
    t_gen2();
    complete_run();
  end
endmodule // loopback_bert_retimer_tb
